// ### hw/kspd_phys_map.sv
`timescale 1ns/10ps
module kspd_phys_map (
  // physical address in
  input  logic [kspd_pkg::PA_W-1:0] pa,
  // target region out
  output kspd_pkg::kspd_region_t    region,
  output logic                      mirror
);
  import kspd_pkg::*;

  logic [PA_LOW_W-1:0] low;

  // only the low bits pick the target above the mirror base
  assign low    = pa[PA_LOW_W-1:0];
  assign mirror = |pa[PA_W-1:PA_LOW_W];

  // descending base compare keeps the ranges disjoint
  always_comb begin
    if (low >= PB_ROM)         region = RG_ROM;
    else if (low >= PB_SYSIO)  region = RG_SYSIO;
    else if (low >= PB_SYSMEM) region = RG_SYSMEM;
    else if (low >= PB_RSVD_H) region = RG_RSVD;
    else if (low >= PB_IIO1)   region = RG_IIO1;
    else if (low >= PB_IIO2)   region = RG_IIO2;
    else if (low >= PB_LCD)    region = RG_LCD;
    else if (low >= PB_RSVD_L) region = RG_RSVD;
    else                       region = RG_DRAM;
  end

endmodule : kspd_phys_map

// ### hw/kspd_pkg.sv
package kspd_pkg;

  // address widths
  localparam int VA_W     = 64;
  localparam int PA_W     = 32;
  localparam int PA_LOW_W = 29;
  localparam int TAG_W    = 8;
  localparam int POL_W    = 3;

  // virtual address field positions
  localparam int VA_SEG_HI = 63;
  localparam int VA_SEG_LO = 62;
  localparam int ERR_HI    = 58;
  localparam int ERR_LO    = 32;
  localparam int CPOL_HI   = 61;
  localparam int CPOL_LO   = 59;
  localparam int CMP_HI    = 61;
  localparam int CMP_LO    = 31;
  localparam int CSEL_HI   = 30;
  localparam int CSEL_LO   = 29;
  localparam int LOW_HI    = 28;

  // top two virtual bits
  localparam logic [1:0] VA_USER = 2'h0;
  localparam logic [1:0] VA_SUPV = 2'h1;
  localparam logic [1:0] VA_PHYS = 2'h2;
  localparam logic [1:0] VA_KERN = 2'h3;

  // compatibility selector values
  localparam logic [1:0] CSEL_CACHED = 2'h0;
  localparam logic [1:0] CSEL_UNC    = 2'h1;
  localparam logic [1:0] CSEL_SUPV   = 2'h2;
  localparam logic [1:0] CSEL_KERN   = 2'h3;

  // cache policy code meaning uncached
  localparam logic [POL_W-1:0] POL_UNCACHED = 3'h2;

  // physical region bases within the low 512 Mbytes
  localparam logic [PA_LOW_W-1:0] PB_ROM    = 29'h1800_0000;
  localparam logic [PA_LOW_W-1:0] PB_SYSIO  = 29'h1400_0000;
  localparam logic [PA_LOW_W-1:0] PB_SYSMEM = 29'h1000_0000;
  localparam logic [PA_LOW_W-1:0] PB_RSVD_H = 29'h0D00_0000;
  localparam logic [PA_LOW_W-1:0] PB_IIO1   = 29'h0C00_0000;
  localparam logic [PA_LOW_W-1:0] PB_IIO2   = 29'h0B00_0000;
  localparam logic [PA_LOW_W-1:0] PB_LCD    = 29'h0A00_0000;
  localparam logic [PA_LOW_W-1:0] PB_RSVD_L = 29'h0400_0000;

  // register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LAST_VALO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LAST_VAHI = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_LAST_PA   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ERR_CNT   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PROBE_LO  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PROBE_HI  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PROBE_PA  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PROBE_RES = 8'h24;

  // reset values
  localparam logic [POL_W-1:0] CTRL_POL_RESET = 3'h2;
  localparam logic [TAG_W-1:0] CTRL_TAG_RESET = 8'h00;
  localparam int ST_ERR_BIT = 16;

  typedef enum logic [3:0] {
    SEG_NONE, SEG_USER, SEG_SUPV, SEG_PHYS, SEG_KERN,
    SEG_C_CACHED, SEG_C_UNCACHED, SEG_C_SUPV, SEG_C_KERN
  } kspd_seg_t;

  typedef enum logic [3:0] {
    RG_DRAM, RG_RSVD, RG_LCD, RG_IIO2, RG_IIO1,
    RG_SYSMEM, RG_SYSIO, RG_ROM
  } kspd_region_t;

  typedef struct packed {
    logic [VA_W-1:0] va;
    logic [PA_W-1:0] tlb_pa;
    logic            page_c;
  } kspd_req_t;

  typedef struct packed {
    kspd_seg_t       seg;
    kspd_region_t    region;
    logic            mapped;
    logic            cached;
    logic            addr_err;
    logic            mirror;
    logic [TAG_W-1:0] tag;
    logic [PA_W-1:0] pa;
  } kspd_res_t;

  typedef struct packed {
    logic [15:0]      zero_hi;
    logic [TAG_W-1:0] tag;
    logic [3:0]       zero_lo;
    logic [POL_W-1:0] pol;
    logic             wide;
  } kspd_ctrl_t;

  typedef struct packed {
    logic [13:0]  zero_hi;
    logic         seen;
    logic         err_flag;
    logic [3:0]   zero_lo;
    logic         addr_err;
    logic         cached;
    logic         mapped;
    logic         mirror;
    kspd_region_t region;
    kspd_seg_t    seg;
  } kspd_stat_t;

endpackage : kspd_pkg

// ### hw/kspd_seg_class.sv
`timescale 1ns/10ps
module kspd_seg_class (
  // request and control
  input  kspd_pkg::kspd_req_t  req,
  input  kspd_pkg::kspd_ctrl_t ctrl,
  // classification, region left to the physical map
  output kspd_pkg::kspd_res_t  res
);
  import kspd_pkg::*;

  logic compat;

  // compatibility needs bits 61..31 all set
  assign compat = &req.va[CMP_HI:CMP_LO];

  // segment sort, one path per top-bit value
  always_comb begin
    res          = '0;
    res.seg      = SEG_NONE;
    res.region   = RG_DRAM;
    res.tag      = ctrl.tag;
    res.pa       = req.tlb_pa;
    if (ctrl.wide) begin
      case (req.va[VA_SEG_HI:VA_SEG_LO])
        VA_SUPV: begin
          res.seg    = SEG_SUPV;
          res.mapped = 1'b1;
          res.cached = req.page_c;
        end
        VA_PHYS: begin
          res.seg      = SEG_PHYS;
          res.addr_err = |req.va[ERR_HI:ERR_LO];
          res.cached   = req.va[CPOL_HI:CPOL_LO] != POL_UNCACHED;
          res.pa       = req.va[PA_W-1:0];
        end
        VA_KERN: begin
          if (!compat) begin
            res.seg    = SEG_KERN;
            res.mapped = 1'b1;
            res.cached = req.page_c;
          end else begin
            // low two selector bits pick the segment
            case (req.va[CSEL_HI:CSEL_LO])
              CSEL_CACHED: begin
                res.seg    = SEG_C_CACHED;
                res.cached = ctrl.pol != POL_UNCACHED;
                res.pa     = {{(PA_W-PA_LOW_W){1'b0}},
                              req.va[LOW_HI:0]};
              end
              CSEL_UNC: begin
                res.seg    = SEG_C_UNCACHED;
                res.pa     = {{(PA_W-PA_LOW_W){1'b0}},
                              req.va[LOW_HI:0]};
              end
              CSEL_SUPV: begin
                res.seg    = SEG_C_SUPV;
                res.mapped = 1'b1;
                res.cached = req.page_c;
              end
              default: begin
                res.seg    = SEG_C_KERN;
                res.mapped = 1'b1;
                res.cached = req.page_c;
              end
            endcase
          end
        end
        default: res.seg = SEG_USER; // user space is decoded elsewhere
      endcase
    end
  end

endmodule : kspd_seg_class

// ### hw/kspd_top.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
module kspd_top #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [kspd_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // core address path
  input  wire logic                          req_valid,
  input  kspd_pkg::kspd_req_t                req,
  // classified result, one cycle later
  output logic                               res_valid,
  output kspd_pkg::kspd_res_t                res
);
  import kspd_pkg::*;

  typedef struct packed {
    kspd_ctrl_t       ctrl;
    logic             err_flag;
    logic             seen;
    logic [VA_W-1:0]  last_va;
    logic [CNT_W-1:0] err_cnt;
    logic [VA_W-1:0]  probe_va;
    logic [PA_W-1:0]  probe_pa;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             res_valid;
    kspd_res_t        res;
  } kspd_state_t;

  kspd_state_t st_reg;
  kspd_state_t st_next;

  kspd_res_t    core_cls;
  kspd_region_t core_region;
  logic         core_mirror;
  kspd_res_t    probe_cls;
  kspd_region_t probe_region;
  logic         probe_mirror;
  kspd_req_t    probe_req;

  logic         setup_ph;
  logic         access_ph;
  logic         wr_take;
  logic         hit;
  logic [31:0]  rdata;
  kspd_stat_t   stat_word;
  kspd_stat_t   probe_word;
  kspd_res_t    core_full;
  kspd_res_t    probe_full;

  // core path classifier
  kspd_seg_class u_core_cls (
    .req  (req),
    .ctrl (st_reg.ctrl),
    .res  (core_cls)
  );

  // region decode for the core path
  kspd_phys_map u_core_map (
    .pa     (core_cls.pa),
    .region (core_region),
    .mirror (core_mirror)
  );

  // software probe uses the same logic as the core path
  assign probe_req.va     = st_reg.probe_va;
  assign probe_req.tlb_pa = st_reg.probe_pa;
  assign probe_req.page_c = 1'b0; // probe has no page attribute

  kspd_seg_class u_probe_cls (
    .req  (probe_req),
    .ctrl (st_reg.ctrl),
    .res  (probe_cls)
  );

  kspd_phys_map u_probe_map (
    .pa     (probe_cls.pa),
    .region (probe_region),
    .mirror (probe_mirror)
  );

  // merge segment and region into one result word
  always_comb begin
    core_full        = core_cls;
    core_full.region = core_region;
    core_full.mirror = core_mirror;
    probe_full        = probe_cls;
    probe_full.region = probe_region;
    probe_full.mirror = probe_mirror;
  end

  // status and probe words share one layout
  always_comb begin
    stat_word          = '0;
    stat_word.seen     = st_reg.seen;
    stat_word.err_flag = st_reg.err_flag;
    stat_word.addr_err = st_reg.res.addr_err;
    stat_word.cached   = st_reg.res.cached;
    stat_word.mapped   = st_reg.res.mapped;
    stat_word.mirror   = st_reg.res.mirror;
    stat_word.region   = st_reg.res.region;
    stat_word.seg      = st_reg.res.seg;
    probe_word          = '0;
    probe_word.addr_err = probe_full.addr_err;
    probe_word.cached   = probe_full.cached;
    probe_word.mapped   = probe_full.mapped;
    probe_word.mirror   = probe_full.mirror;
    probe_word.region   = probe_full.region;
    probe_word.seg      = probe_full.seg;
  end

  // apb phases; the answer always comes in the first access cycle
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable && st_reg.pready;
  assign wr_take   = access_ph && pwrite && !st_reg.pslverr;

  // read mux and address decode, evaluated in the setup cycle
  always_comb begin
    rdata = '0;
    hit   = 1'b1;
    case (paddr)
      OFS_CTRL:      rdata = st_reg.ctrl;
      OFS_STATUS:    rdata = stat_word;
      OFS_LAST_VALO: rdata = st_reg.last_va[31:0];
      OFS_LAST_VAHI: rdata = st_reg.last_va[VA_W-1:32];
      OFS_LAST_PA:   rdata = st_reg.res.pa;
      OFS_ERR_CNT:   rdata = 32'(st_reg.err_cnt);
      OFS_PROBE_LO:  rdata = st_reg.probe_va[31:0];
      OFS_PROBE_HI:  rdata = st_reg.probe_va[VA_W-1:32];
      OFS_PROBE_PA:  rdata = st_reg.probe_pa;
      OFS_PROBE_RES: rdata = probe_word;
      default: begin
        rdata = '0;
        hit   = 1'b0; // unmapped or misaligned offset
      end
    endcase
  end

  // next state of the whole block
  always_comb begin
    st_next = st_reg;

    // apb answer registers; ready and error last only the access cycle, read data holds until the next setup
    st_next.pready  = setup_ph;
    st_next.pslverr = setup_ph && !hit;
    if (setup_ph) begin
      st_next.prdata = (!pwrite && hit) ? rdata : '0;
    end

    // software writes take effect at the access edge
    if (wr_take) begin
      case (paddr)
        OFS_CTRL: begin
          st_next.ctrl         = kspd_ctrl_t'(pwdata);
          st_next.ctrl.zero_hi = '0;
          st_next.ctrl.zero_lo = '0;
        end
        OFS_STATUS: begin
          if (pwdata[ST_ERR_BIT]) begin
            st_next.err_flag = 1'b0; // write one to clear
          end
        end
        OFS_ERR_CNT:  st_next.err_cnt = '0;
        OFS_PROBE_LO: st_next.probe_va[31:0] = pwdata;
        OFS_PROBE_HI: st_next.probe_va[VA_W-1:32] = pwdata;
        OFS_PROBE_PA: st_next.probe_pa = pwdata;
        default: begin
          st_next.ctrl = st_next.ctrl; // read-only, write ignored
        end
      endcase
    end

    // core requests: register the classification for the next cycle
    st_next.res_valid = req_valid;
    if (req_valid) begin
      st_next.res     = core_full;
      st_next.last_va = req.va;
      st_next.seen    = 1'b1;
      if (core_full.addr_err) begin
        // a new error beats a clear in the same cycle
        st_next.err_flag = 1'b1;
        if (!(wr_take && paddr == OFS_ERR_CNT)) begin
          if (st_reg.err_cnt != '1) begin
            st_next.err_cnt = st_reg.err_cnt + CNT_W'(1); // saturates
          end
        end else begin
          st_next.err_cnt = CNT_W'(1);
        end
      end
    end
  end

  // one register for all state; only constants under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg          <= '0;
      st_reg.ctrl.pol <= CTRL_POL_RESET;
      st_reg.ctrl.tag <= CTRL_TAG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register
  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign res_valid = st_reg.res_valid;
  assign res       = st_reg.res;

endmodule : kspd_top

// ### verif/kspd_core_model.sv
`timescale 1ns/10ps
module kspd_core_model (
  // clock
  input  wire logic           pclk,
  // request toward the decoder
  output logic                req_valid,
  output kspd_pkg::kspd_req_t req
);
  import kspd_pkg::*;

  // idle from time zero
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // one request per call; fields scrambled once released so that a
  // design reading a stale request is caught
  task automatic issue(input logic [VA_W-1:0] va, input logic [PA_W-1:0] tp,
                       input logic pc);
    @(posedge pclk);
    req_valid <= 1'b1;
    req       <= '{va: va, tlb_pa: tp, page_c: pc};
    @(posedge pclk);
    req_valid <= 1'b0;
    req       <= '{va: ~va, tlb_pa: ~tp, page_c: ~pc};
  endtask : issue
endmodule : kspd_core_model

// ### verif/kspd_properties.sv
`timescale 1ns/10ps
module kspd_checker (
  // clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // apb handshake
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pready,
  // core request and result
  input wire logic            req_valid,
  input kspd_pkg::kspd_req_t  req,
  input wire logic            res_valid,
  input kspd_pkg::kspd_res_t  res
);
  import kspd_pkg::*;
  logic [VA_W-1:0] va_q;
  logic [PA_W-1:0] tp_q;
  logic            pc_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // last accepted request, lined up with its result
  always_ff @(posedge pclk) begin
    if (req_valid) begin
      va_q <= req.va;
      tp_q <= req.tlb_pa;
      pc_q <= req.page_c;
    end
  end

  // expected region of the low 29 bits, highest base first
  function automatic kspd_region_t rg(input logic [PA_LOW_W-1:0] a);
    return a >= PB_ROM ? RG_ROM : a >= PB_SYSIO ? RG_SYSIO :
      a >= PB_SYSMEM ? RG_SYSMEM : a >= PB_RSVD_H ? RG_RSVD :
      a >= PB_IIO1 ? RG_IIO1 : a >= PB_IIO2 ? RG_IIO2 :
      a >= PB_LCD ? RG_LCD : a >= PB_RSVD_L ? RG_RSVD : RG_DRAM;
  endfunction : rg

  result_timing_a: assert property (req_valid |=> res_valid)
    else $error("no result one cycle after request");
  result_pulse_a: assert property ($fell(req_valid) |-> res_valid ##1 !res_valid)
    else $error("result strobe longer than its request");
  phys_err_a: assert property (res_valid && res.seg == SEG_PHYS |->
    res.addr_err == (|va_q[ERR_HI:ERR_LO])) else $error("window error wrong");
  phys_cache_a: assert property (res_valid && res.seg == SEG_PHYS |->
    res.cached == (va_q[CPOL_HI:CPOL_LO] != POL_UNCACHED) && !res.mapped
    && res.pa == va_q[PA_W-1:0]) else $error("window result wrong");
  compat_sel_a: assert property (res_valid && res.seg != SEG_NONE
    && (&va_q[VA_SEG_HI:CMP_LO]) |-> res.seg == kspd_seg_t'(4'h5 +
    va_q[CSEL_HI:CSEL_LO])) else $error("compat segment wrong");
  direct_low_a: assert property (res_valid && res.seg inside
    {SEG_C_CACHED, SEG_C_UNCACHED} |-> !res.mapped
    && res.pa == {3'h0, va_q[LOW_HI:0]}) else $error("direct pa wrong");
  unc_direct_a: assert property (res_valid
    && res.seg == SEG_C_UNCACHED |-> !res.cached) else $error("cached");
  mapped_pa_a: assert property (res_valid && res.seg inside {SEG_SUPV,
    SEG_KERN, SEG_C_SUPV, SEG_C_KERN} |-> res.mapped && res.pa == tp_q
    && res.cached == pc_q) else $error("mapped result wrong");
  kern_top_a: assert property (res_valid && res.seg == SEG_KERN |->
    va_q[VA_SEG_HI:VA_SEG_LO] == VA_KERN && !(&va_q[CMP_HI:CMP_LO]))
    else $error("kernel segment wrong");
  region_map_a: assert property (res_valid |->
    res.region == rg(res.pa[PA_LOW_W-1:0])
    && res.mirror == (|res.pa[PA_W-1:PA_LOW_W])) else $error("region wrong");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule : kspd_checker

bind kspd_top kspd_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .req_valid(req_valid),
  .req(req), .res_valid(res_valid), .res(res));

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  import kspd_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, req_valid, res_valid, er;
  kspd_req_t         req;
  kspd_res_t         res;
  int                bad_count, num_checks;
  kspd_seg_t         cseg [4] = '{SEG_C_CACHED, SEG_C_UNCACHED, SEG_C_SUPV,
                                  SEG_C_KERN};
  logic [31:0]       rpa [16] = '{32'h0, 32'h03FF_FFFF, 32'h0400_0000,
    32'h09FF_FFFF, 32'h0A00_0000, 32'h0AFF_FFFF, 32'h0B00_0000,
    32'h0BFF_FFFF, 32'h0C00_0000, 32'h0CFF_FFFF, 32'h0D00_0000,
    32'h1000_0000, 32'h1400_0000, 32'h1800_0000, 32'h2000_0000,
    32'hFFFF_FFFF};
  kspd_region_t      rrg [16] = '{RG_DRAM, RG_DRAM, RG_RSVD, RG_RSVD,
    RG_LCD, RG_LCD, RG_IIO2, RG_IIO2, RG_IIO1, RG_IIO1, RG_RSVD,
    RG_SYSMEM, RG_SYSIO, RG_ROM, RG_DRAM, RG_ROM};

  kspd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(req_valid), .req(req), .res_valid(res_valid), .res(res));
  kspd_core_model core (.pclk(pclk), .req_valid(req_valid), .req(req));

  // 25 MHz clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits on pready, never on a fixed count
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait that never sees ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic set_ctrl(input logic [7:0] t, input logic [2:0] p,
                          input logic w);
    apb(1'b1, OFS_CTRL, {16'h0, t, 4'h0, p, w});
  endtask : set_ctrl

  // issue through the core model, then compare the result fields
  task automatic expect_res(input logic [63:0] va, input logic [31:0] tp,
    input logic pc, input kspd_seg_t s, input logic m, c, e,
    input logic [31:0] pa);
    int n;
    n = 0;
    core.issue(va, tp, pc);
    #1;
    while (res_valid !== 1'b1 && n < 4) begin
      n++;
      @(posedge pclk);
      #1;
    end
    chk(res_valid, 1'b1);
    chk(res.seg, s);
    chk(res.mapped, m);
    chk(res.cached, c);
    chk(res.addr_err, e);
    chk(res.pa, pa);
  endtask : expect_res

  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0000_0004);
    apb(1'b0, 8'h40, 32'h0);
    chk(er, 1'b1);
    $display("test reset done");
  endtask : t_reset

  // every cache code, then two address errors and their bookkeeping
  task automatic t_phys();
    set_ctrl(8'h00, 3'h2, 1'b1);
    apb(1'b1, OFS_ERR_CNT, 32'h0);
    for (int i = 0; i < 8; i++)
      expect_res({2'h2, i[2:0], 27'h0, 32'hC0DE_0010}, 32'h0, 1'b0, SEG_PHYS,
                 1'b0, i != 2, 1'b0, 32'hC0DE_0010);
    expect_res({2'h2, 3'h0, 27'h1, 32'h10}, 32'h0, 1'b0, SEG_PHYS,
               1'b0, 1'b1, 1'b1, 32'h10);
    expect_res({2'h2, 3'h0, 27'h400_0000, 32'h10}, 32'h0, 1'b0, SEG_PHYS,
               1'b0, 1'b1, 1'b1, 32'h10);
    apb(1'b0, OFS_ERR_CNT, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, OFS_STATUS, 32'h0001_0000);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[ST_ERR_BIT], 1'b0);
    $display("test phys done");
  endtask : t_phys

  // all four compat segments under both an uncached and a cached policy
  task automatic t_compat();
    for (int p = 2; p < 4; p++) begin
      set_ctrl(8'hA5, p[2:0], 1'b1);
      for (int s = 0; s < 4; s++) begin
        expect_res({33'h1_FFFF_FFFF, s[1:0], 29'h0ABC_DEF0}, 32'h1234_5678,
          1'b1, cseg[s], s[1], s[1] | (s == 0 && p != 2), 1'b0,
          s[1] ? 32'h1234_5678 : 32'h0ABC_DEF0);
        chk(res.tag, 8'hA5);
      end
    end
    $display("test compat done");
  endtask : t_compat

  // one bit short of compat falls to kernel; narrow mode selects nothing
  task automatic t_segs();
    expect_res(64'h4000_0000_0000_1000, 32'h100, 1'b0, SEG_SUPV, 1'b1,
               1'b0, 1'b0, 32'h100);
    expect_res(64'hFFFF_FFFE_FFFF_F000, 32'h0200_0000, 1'b1, SEG_KERN, 1'b1,
               1'b1, 1'b0, 32'h0200_0000);
    apb(1'b0, OFS_LAST_VAHI, 32'h0);
    chk(rd, 32'hFFFF_FFFE);
    // software probe of a window address: phys segment, cached, dram
    apb(1'b1, OFS_PROBE_HI, 32'h8000_0000);
    apb(1'b1, OFS_PROBE_LO, 32'h0000_0010);
    apb(1'b0, OFS_PROBE_RES, 32'h0);
    chk(rd, 32'h0000_0403);
    set_ctrl(8'h00, 3'h2, 1'b0);
    expect_res(64'hFFFF_FFFF_8000_0000, 32'h0, 1'b0, SEG_NONE, 1'b0,
               1'b0, 1'b0, 32'h0);
    $display("test segs done");
  endtask : t_segs

  // region edges and mirror images through the window
  task automatic t_regions();
    set_ctrl(8'h00, 3'h2, 1'b1);
    for (int i = 0; i < 16; i++) begin
      expect_res({32'h8000_0000, rpa[i]}, 32'h0, 1'b0, SEG_PHYS, 1'b0,
                 1'b1, 1'b0, rpa[i]);
      chk(res.region, rrg[i]);
      chk(res.mirror, i >= 14);
    end
    $display("test regions done");
  endtask : t_regions

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = '0;
    bad_count  = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_phys();
    t_compat();
    t_segs();
    t_regions();
    wrap_up();
  end

  // watchdog, far beyond the roughly 140 cycles the tests need
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : tb
